// file: logic/pcic_cfg.svh
// pcic_cfg.svh: offsets, field positions, reset values and timing counts
// assumes a 32-bit axi4-lite word map and a 20 MHz core clock
`ifndef PCIC_CFG_SVH
`define PCIC_CFG_SVH

`define PCIC_OFF_UNLOCK 8'h00
`define PCIC_OFF_PASSWORD 8'h04
`define PCIC_OFF_CONFIG 8'h08
`define PCIC_OFF_FACTOR 8'h0c
`define PCIC_OFF_SETPOINT2 8'h10
`define PCIC_OFF_OFFSET 8'h14
`define PCIC_OFF_CONTROL 8'h18
`define PCIC_OFF_COUNT 8'h1c
`define PCIC_OFF_STATUS 8'h20

`define PCIC_CFG_R1POL 0
`define PCIC_CFG_R2POL 1
`define PCIC_CFG_INPOL 2
`define PCIC_CFG_SPEED 3
`define PCIC_CFG_MODE_LO 4
`define PCIC_CFG_MODE_HI 7

`define PCIC_CTL_LOAD 0
`define PCIC_CTL_TRIG1 1
`define PCIC_CTL_TRIG2 2

`define PCIC_PASSWORD_MAX 14'h270f
`define PCIC_PASSWORD_RST 14'h0000
`define PCIC_FACTOR_MIN 20'h00001
`define PCIC_FACTOR_MAX 20'hf423f
`define PCIC_FACTOR_RST 20'h186a0
`define PCIC_MODE_QUAD 4'hc

`define PCIC_CLK_MHZ 20
`define PCIC_LOCKOUT_US 9000
`define PCIC_LOCKOUT_CYC (`PCIC_LOCKOUT_US * `PCIC_CLK_MHZ)

`define PCIC_RESP_OKAY 2'h0
`define PCIC_RESP_SLVERR 2'h2

`endif

// file: logic/pcic_pkg.sv
// pcic_pkg.sv: types shared by the pulse counter configuration block
// assumes the constants of pcic_cfg.svh
`default_nettype none
package pcic_pkg;

  typedef enum logic [2:0] {
    WR_IDLE = 3'h1,
    WR_DO = 3'h2,
    WR_RESP = 3'h4
  } pcic_wr_state_type;

  typedef struct packed {
    logic [1:0] sync_shift;
    logic sync_last;
    logic stable;
    logic active;
    logic [17:0] lock_cnt;
    logic pulse;
  } pcic_qual_type;

  typedef struct packed {
    pcic_wr_state_type wr_state;
    logic awready;
    logic wready;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic unlocked;
    logic [13:0] password;
    logic [7:0] config_bits;
    logic [19:0] factor;
    logic [31:0] setpoint2;
    logic [31:0] offset;
    logic trig1;
    logic trig2;
    logic signed [31:0] count;
    logic relay1;
    logic relay2;
  } pcic_state_type;

endpackage
`default_nettype wire

// file: logic/pcic_input_qual.sv
// pcic_input_qual.sv: one counting input, synchronised, polarity
// corrected and qualified into single-cycle pulses
// assumes an asynchronous pin and a lockout count fitting 18 bits
`timescale 1ns/100ps
`default_nettype none
module pcic_input_qual #(
  parameter logic [17:0] LOCKOUT_CYC = 18'h2bf20
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic invert_in,
  input wire logic filter_en_in,
  output logic level_out,
  output logic pulse_out
);
  pcic_pkg::pcic_qual_type st, next_st;
  logic next_active;

  always_comb begin
    next_st = st;
    next_st.sync_shift = {st.sync_shift[0], pin_in};
    next_st.sync_last = st.sync_shift[1];
    // a change counts only once second and third stage agree
    if (st.sync_shift[1] == st.sync_last) begin
      next_st.stable = st.sync_last;
    end
    next_active = st.stable ^ invert_in; // [R15] [R4]
    next_st.active = next_active;
    next_st.pulse = 1'b0;
    if (st.lock_cnt != 18'h00000) begin
      next_st.lock_cnt = st.lock_cnt - 18'h00001;
    end
    if (next_active && !st.active) begin
      if (!filter_en_in) begin
        next_st.pulse = 1'b1; // [R7] [R6]
        next_st.lock_cnt = 18'h00000;
      end else if (st.lock_cnt == 18'h00000) begin
        next_st.pulse = 1'b1; // [R5]
        next_st.lock_cnt = LOCKOUT_CYC;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // pins idle high at the default active-low polarity: start there
      // so that no false edge follows reset
      st <= '0;
      st.sync_shift <= 2'h3;
      st.sync_last <= 1'h1;
      st.stable <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.active;
  assign pulse_out = st.pulse;
endmodule
`default_nettype wire

// file: logic/pcic_top.sv
// pcic_top.sv: pulse counter input and relay configuration with an
// axi4-lite register slave, password gate, mode decode and main count
// assumes counting inputs from sensors or dry contacts on pins
//
// Contract
// (R1) config changes are refused until the 0000..9999 access code matches
// (R2) first relay closes on trigger at polarity 0, opens at 1
// (R3) second relay closes on trigger at polarity 0, opens at 1
// (R4) one polarity select sets active level of all inputs
// (R5) slow mode filters and locks out an input for 9 ms per pulse
// (R6) mode codes 12 and up bypass the slow filter
// (R7) fast mode accepts pulses with no filter or lockout
// (R8) down modes start the count from set point 2
// (R9) up modes start the count from the offset
// (R10) two-input modes use the second input as a counting input
// (R11) mode 0 holds and subtracts; mode 1 holds and adds
// (R12) mode 4 sub/sub, 5 sub2/add1, 6 add2/sub1
// (R13) each accepted pulse moves the count by the conversion factor
// (R14) in hold modes an asserted hold input freezes the count
// (R15) polarity is corrected before pulse qualification
`include "pcic_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module pcic_top #(
  parameter logic [17:0] LOCKOUT_CYC = 18'(`PCIC_LOCKOUT_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic primary_count_input_in,
  input wire logic secondary_count_input_in,
  output logic first_relay_output_out,
  output logic second_relay_output_out
);
  pcic_pkg::pcic_state_type st, next_st;
  logic [3:0] mode;
  logic quad_mode;
  logic filter_en;
  logic invert;
  logic prim_level, prim_pulse, sec_level, sec_pulse;
  logic hold_mode, dir_up;
  logic signed [31:0] fac;
  logic signed [31:0] delta;
  logic [31:0] merged;
  logic [31:0] cur;
  logic [31:0] rd;
  logic rd_ok;
  logic wr_ok;

  assign mode = st.config_bits[`PCIC_CFG_MODE_HI:`PCIC_CFG_MODE_LO];
  assign quad_mode = mode >= `PCIC_MODE_QUAD;
  // slow filter only in slow speed and outside quadrature modes
  assign filter_en = !st.config_bits[`PCIC_CFG_SPEED] && !quad_mode; // [R6]
  // polarity 0 means sinking sources, so the pin is active low
  assign invert = !st.config_bits[`PCIC_CFG_INPOL]; // [R4]

  pcic_input_qual #(
    .LOCKOUT_CYC(LOCKOUT_CYC)
  ) u_prim (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(primary_count_input_in),
    .invert_in(invert),
    .filter_en_in(filter_en),
    .level_out(prim_level),
    .pulse_out(prim_pulse)
  );

  pcic_input_qual #(
    .LOCKOUT_CYC(LOCKOUT_CYC)
  ) u_sec (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(secondary_count_input_in),
    .invert_in(invert),
    .filter_en_in(filter_en),
    .level_out(sec_level),
    .pulse_out(sec_pulse)
  );

  // mode decode and per-pulse delta; both inputs may fire together
  always_comb begin
    fac = signed'({12'h000, st.factor});
    delta = 32'sh0;
    hold_mode = 1'b0;
    dir_up = 1'b0;
    unique case (mode)
      4'h0: begin
        hold_mode = 1'b1;
        if (prim_pulse && !sec_level) begin
          delta = -fac; // [R11] [R14]
        end
      end
      4'h1: begin
        hold_mode = 1'b1;
        dir_up = 1'b1;
        if (prim_pulse && !sec_level) begin
          delta = fac; // [R11] [R14]
        end
      end
      4'h4: begin
        delta = (prim_pulse ? -fac : 32'sh0)
          + (sec_pulse ? -fac : 32'sh0); // [R12] [R10]
      end
      4'h5: begin
        dir_up = 1'b1;
        delta = (prim_pulse ? fac : 32'sh0)
          + (sec_pulse ? -fac : 32'sh0); // [R12] [R10]
      end
      4'h6: begin
        delta = (prim_pulse ? -fac : 32'sh0)
          + (sec_pulse ? fac : 32'sh0); // [R12] [R10]
      end
      4'h7: begin
        dir_up = 1'b1;
        delta = (prim_pulse ? fac : 32'sh0)
          + (sec_pulse ? fac : 32'sh0);
      end
      // other codes belong to modes not built here: no counting
      default: begin
        delta = 32'sh0;
      end
    endcase
  end

  // current value of the addressed word, for byte-lane merging
  always_comb begin
    cur = 32'h00000000;
    unique case (st.waddr)
      `PCIC_OFF_PASSWORD: cur = {18'h00000, st.password};
      `PCIC_OFF_CONFIG: cur = {24'h000000, st.config_bits};
      `PCIC_OFF_FACTOR: cur = {12'h000, st.factor};
      `PCIC_OFF_SETPOINT2: cur = st.setpoint2;
      `PCIC_OFF_OFFSET: cur = st.offset;
      `PCIC_OFF_CONTROL: cur = {29'h00000000, st.trig2, st.trig1, 1'b0};
      default: cur = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = st.wstrb[i] ? st.wdata[i*8 +: 8] : cur[i*8 +: 8];
    end
  end

  // read mux
  always_comb begin
    rd = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_in)
      `PCIC_OFF_UNLOCK: rd = {31'h00000000, st.unlocked};
      `PCIC_OFF_PASSWORD: rd = 32'h00000000; // code is never readable
      `PCIC_OFF_CONFIG: rd = {24'h000000, st.config_bits};
      `PCIC_OFF_FACTOR: rd = {12'h000, st.factor};
      `PCIC_OFF_SETPOINT2: rd = st.setpoint2;
      `PCIC_OFF_OFFSET: rd = st.offset;
      `PCIC_OFF_CONTROL: rd = {29'h00000000, st.trig2, st.trig1, 1'b0};
      `PCIC_OFF_COUNT: rd = st.count;
      `PCIC_OFF_STATUS:
        rd = {27'h0000000, hold_mode && sec_level, sec_level, prim_level,
          filter_en, st.unlocked};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    wr_ok = 1'b1;
    // write address and data are taken independently, in either order
    if (s_axi_awvalid_in && st.awready) begin
      next_st.awready = 1'b0;
      next_st.waddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.wready = 1'b0;
      next_st.wdata = s_axi_wdata_in;
      next_st.wstrb = s_axi_wstrb_in;
    end
    // count update, overridden below by a start-value load
    next_st.count = st.count + delta; // [R13]
    unique case (st.wr_state)
      pcic_pkg::WR_IDLE: begin
        if (!next_st.awready && !next_st.wready) begin
          next_st.wr_state = pcic_pkg::WR_DO;
        end
      end
      pcic_pkg::WR_DO: begin
        next_st.wr_state = pcic_pkg::WR_RESP;
        next_st.bvalid = 1'b1;
        unique case (st.waddr)
          `PCIC_OFF_UNLOCK: begin
            // any mismatch relocks the configuration
            next_st.unlocked = (st.wdata[13:0] == st.password)
              && (st.wdata[31:14] == 18'h00000); // [R1]
          end
          `PCIC_OFF_PASSWORD: begin
            if (st.unlocked && merged[31:14] == 18'h00000
                && merged[13:0] <= `PCIC_PASSWORD_MAX) begin
              next_st.password = merged[13:0]; // [R1]
            end
          end
          `PCIC_OFF_CONFIG: begin
            if (st.unlocked) begin
              next_st.config_bits = merged[7:0]; // [R1]
            end
          end
          `PCIC_OFF_FACTOR: begin
            // out-of-range factors are dropped rather than clipped
            if (st.unlocked && merged[31:20] == 12'h000
                && merged[19:0] >= `PCIC_FACTOR_MIN
                && merged[19:0] <= `PCIC_FACTOR_MAX) begin
              next_st.factor = merged[19:0]; // [R1] [R13]
            end
          end
          `PCIC_OFF_SETPOINT2: begin
            if (st.unlocked) begin
              next_st.setpoint2 = merged;
            end
          end
          `PCIC_OFF_OFFSET: begin
            if (st.unlocked) begin
              next_st.offset = merged;
            end
          end
          `PCIC_OFF_CONTROL: begin
            next_st.trig1 = merged[`PCIC_CTL_TRIG1];
            next_st.trig2 = merged[`PCIC_CTL_TRIG2];
            if (merged[`PCIC_CTL_LOAD]) begin
              // load wins over a pulse counted in the same cycle
              next_st.count = dir_up ? st.offset : st.setpoint2; // [R8] [R9]
            end
          end
          default: wr_ok = 1'b0;
        endcase
        next_st.bresp = wr_ok ? `PCIC_RESP_OKAY : `PCIC_RESP_SLVERR;
      end
      pcic_pkg::WR_RESP: begin
        if (s_axi_bready_in) begin
          next_st.bvalid = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready = 1'b1;
          next_st.wr_state = pcic_pkg::WR_IDLE;
        end
      end
      default: begin
        next_st.wr_state = pcic_pkg::WR_IDLE;
      end
    endcase
    // read: one at a time, arready drops while the answer stands
    if (s_axi_arvalid_in && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = rd_ok ? `PCIC_RESP_OKAY : `PCIC_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // relay drive: 1 means contact closed
    next_st.relay1 = st.trig1 ^ st.config_bits[`PCIC_CFG_R1POL]; // [R2]
    next_st.relay2 = st.trig2 ^ st.config_bits[`PCIC_CFG_R2POL]; // [R3]
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.wr_state <= pcic_pkg::WR_IDLE;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.password <= `PCIC_PASSWORD_RST;
      st.factor <= `PCIC_FACTOR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready_out = st.awready;
  assign s_axi_wready_out = st.wready;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = st.arready;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign first_relay_output_out = st.relay1;
  assign second_relay_output_out = st.relay2;
endmodule
`default_nettype wire

// file: dv/pcic_sensor.sv
// pcic_sensor.sv: sensors or dry contacts on both counting pins
// assumes the bench asks for an active or idle state per pin
`timescale 1ns/100ps
`default_nettype none
module pcic_sensor (
  input wire logic pol_in,
  input wire logic [1:0] act_in,
  output logic prim_out,
  output logic sec_out
);
  // sinking parts pull low when active, idle sits at the pull-up
  assign prim_out = act_in[0] ~^ pol_in;
  assign sec_out = act_in[1] ~^ pol_in;
endmodule
`default_nettype wire

// file: dv/pcic_top_sva.sv
// pcic_top_sva.sv: bus handshake and relay checks for pcic_top
// assumes a bind onto pcic_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module pcic_top_sva #(
  parameter logic [17:0] LOCKOUT_CYC = 18'h2bf20
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic first_relay_output_out,
  input wire logic second_relay_output_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_bresp_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  chk_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:4] s_axi_bvalid_out)
    else $error("write not answered");
  chk_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  chk_rdata_hold: assert property (
    s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_busy_write: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write slot open too soon");
  chk_busy_read: assert property (
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read slot open too soon");
  // relays move only as a result of a register write
  chk_relay1_cause: assert property (
    !$stable(first_relay_output_out) |-> $past(s_axi_bvalid_out)
    || $past(s_axi_bvalid_out, 2) || $past(s_axi_bvalid_out, 3))
    else $error("relay1 moved alone");
  chk_relay2_cause: assert property (
    !$stable(second_relay_output_out) |-> $past(s_axi_bvalid_out)
    || $past(s_axi_bvalid_out, 2) || $past(s_axi_bvalid_out, 3))
    else $error("relay2 moved alone");
endmodule
bind pcic_top pcic_top_sva #(.LOCKOUT_CYC(LOCKOUT_CYC)) u_sva (.clk_in,
  .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .first_relay_output_out, .second_relay_output_out);
`default_nettype wire

// file: dv/testbench.sv
// testbench.sv: self-checking bench for pcic_top
// assumes pcic_sensor on the pins and a 20-cycle lockout
`include "pcic_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] UN = `PCIC_OFF_UNLOCK;
  localparam logic [7:0] CT = `PCIC_OFF_CONTROL;
  localparam logic [7:0] CN = `PCIC_OFF_COUNT;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [7:0] aa = '0, ra = '0;
  logic awv = '0, wv = '0, br = '0, arv = '0, rr = '0, pol = '0;
  logic [31:0] wd = '0, rv_d, ex, off, sp;
  logic [1:0] act = '0, rsp;
  logic [19:0] f;
  logic [3:0] ml [6] = '{4'h1, 4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [7:0] tc [3] = '{8'h10, 8'hc0, 8'h18};
  wire logic awr, wrr, bv, arr, rv, r1, r2, p1, p2;
  wire logic [1:0] bs, rs;
  wire logic [31:0] rdat;
  int num_errors = 0;
  int num_checks = 0;
  always #25 clk_in = ~clk_in;
  // short lockout keeps the slow-mode runs brief
  pcic_top #(.LOCKOUT_CYC(18'h14)) u_dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .s_axi_awaddr_in(aa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(bs),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ra),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rs), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rr), .primary_count_input_in(p1),
    .secondary_count_input_in(p2), .first_relay_output_out(r1),
    .second_relay_output_out(r2));
  pcic_sensor u_sens (.pol_in(pol), .act_in(act), .prim_out(p1),
    .sec_out(p2));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task hang;
    num_errors++;
    tally_and_finish();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    aa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrr) wv <= 1'h0;
      if (bv) break;
    end
    rsp = bs;
    br <= 1'h0;
    if (n == 40) hang();
    @(posedge clk_in);
  endtask
  task rd(input logic [7:0] a);
    int n;
    ra <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (arv && arr) arv <= 1'h0;
      if (rv) break;
    end
    rv_d = rdat;
    rsp = rs;
    rr <= 1'h0;
    if (n == 40) hang();
    @(posedge clk_in);
  endtask
  task cfg(input logic [7:0] c);
    wr(`PCIC_OFF_CONFIG, {24'h0, c});
  endtask
  task pulse(input int i, input int w);
    act[i] <= 1'h1;
    repeat (w) @(posedge clk_in);
    act[i] <= 1'h0;
    repeat (w) @(posedge clk_in);
  endtask
  // count step per input and mode, zero where the input only holds
  function logic [31:0] dlt(input logic [3:0] m, input logic s);
    case ({m, s})
      5'h00, 5'h08, 5'h09, 5'h0b, 5'h0c: dlt = -{12'h0, f};
      5'h02, 5'h0a, 5'h0d, 5'h0e, 5'h0f: dlt = {12'h0, f};
      default: dlt = 32'h0;
    endcase
  endfunction
  initial begin
    void'($urandom(32'h8f5e29d5));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    cfg(8'h1f);
    chk("locked write resp", 32'(rsp), 32'h0);
    rd(`PCIC_OFF_CONFIG);
    chk("config locked", rv_d, 32'h0);
    wr(UN, 32'h5);
    rd(UN);
    chk("wrong code", rv_d, 32'h0);
    wr(UN, 32'h0);
    wr(`PCIC_OFF_PASSWORD, 32'h2710);
    wr(UN, 32'h2710);
    rd(UN);
    chk("code above range", rv_d, 32'h0);
    wr(UN, 32'h0);
    wr(`PCIC_OFF_PASSWORD, 32'h270f);
    wr(UN, 32'h0);
    cfg(8'h01);
    rd(`PCIC_OFF_CONFIG);
    chk("relocked", rv_d, 32'h0);
    wr(UN, 32'h270f);
    chk("unlock resp", 32'(rsp), 32'h0);
    rd(UN);
    chk("top code", rv_d, 32'h1);
    rd(8'h40);
    chk("unmapped", 32'(rsp), 32'h2);
    wr(8'h40, 32'h0);
    chk("unmapped write", 32'(rsp), 32'h2);
    for (int i = 0; i < 16; i++) begin
      cfg({6'h0, i[1:0]});
      wr(CT, {29'h0, i[3:2], 1'h0});
      repeat (4) @(posedge clk_in);
      chk("relay1", 32'(r1), 32'(i[2] ^ i[0]));
      chk("relay2", 32'(r2), 32'(i[3] ^ i[1]));
    end
    for (int i = 0; i < 3; i++) begin
      cfg(tc[i]);
      rd(`PCIC_OFF_STATUS);
      chk("filter", 32'(rv_d[1]), 32'(i == 0));
    end
    f = 20'($urandom_range(999999, 1));
    off = $urandom_range(65535, 0);
    sp = $urandom_range(65535, 0);
    wr(`PCIC_OFF_FACTOR, {12'h0, f});
    wr(`PCIC_OFF_FACTOR, 32'h0);
    rd(`PCIC_OFF_FACTOR);
    chk("factor", rv_d, {12'h0, f});
    wr(`PCIC_OFF_OFFSET, off);
    wr(`PCIC_OFF_SETPOINT2, sp);
    for (int i = 0; i < 6; i++) begin
      pol <= i[0];
      repeat (8) @(posedge clk_in);
      cfg({ml[i], 1'h1, i[0], 2'h0});
      repeat (8) @(posedge clk_in);
      wr(CT, 32'h1);
      ex = (ml[i] == 0 || ml[i] == 4 || ml[i] == 6) ? sp : off;
      rd(CN);
      chk("load", rv_d, ex);
      pulse(0, 6);
      pulse(1, 6);
      pulse(0, 6);
      ex = ex + dlt(ml[i], 1'h0) + dlt(ml[i], 1'h1) + dlt(ml[i], 1'h0);
      repeat (4) @(posedge clk_in);
      rd(CN);
      chk("count", rv_d, ex);
    end
    cfg(8'h0c);
    wr(CT, 32'h1);
    act[1] <= 1'h1;
    repeat (8) @(posedge clk_in);
    pulse(0, 6);
    rd(CN);
    chk("held", rv_d, sp);
    rd(`PCIC_OFF_STATUS);
    chk("hold flags", 32'(rv_d[4:2]), 32'h6);
    act[1] <= 1'h0;
    repeat (8) @(posedge clk_in);
    pulse(0, 6);
    repeat (4) @(posedge clk_in);
    rd(CN);
    chk("released", rv_d, sp - {12'h0, f});
    cfg(8'h14);
    repeat (8) @(posedge clk_in);
    wr(CT, 32'h1);
    pulse(0, 6);
    pulse(0, 6);
    repeat (30) @(posedge clk_in);
    pulse(0, 6);
    repeat (4) @(posedge clk_in);
    rd(CN);
    chk("lockout", rv_d, off + {11'h0, f, 1'h0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
